// ---- src/pnp_defines.vh ----
// constants for the stored-setting command block
`ifndef PNP_DEFINES_VH
`define PNP_DEFINES_VH

// command opcodes (upper nibble of the opcode byte)
`define PNP_OP_ERASE     4'hd
`define PNP_OP_PROG      4'h2
`define PNP_OP_PROG_TAP  4'h3
`define PNP_OP_READ_NV   4'ha
`define PNP_OP_READ_TAP  4'hc

// frame layout
`define PNP_FRAME_BITS   5'h18
`define PNP_OP_MSB       23
`define PNP_OP_LSB       20
`define PNP_SLOT_MSB     19
`define PNP_SLOT_LSB     18
`define PNP_CHAN_MSB     17
`define PNP_CHAN_LSB     16
`define PNP_MODE_BIT     8

// stored word: buffer mode bit above eight wiper bits
`define PNP_WORD_BITS    9
`define PNP_ERASED_WORD  9'h1ff
`define PNP_TAP_RESET    8'h80

// store duration: 2 ms maximum, 20000 clocks at 100 ns
`define PNP_STORE_CYC    22'h004e20

`endif

// ---- src/pnp_sync.v ----
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pnp_sync #(
    parameter W = 3
) (
    input  wire         i_clk,
    input  wire         i_rstn,
    input  wire [W-1:0] i_d,
    output wire [W-1:0] o_q
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // first stage is read only by the second
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= i_d;
            sync_q <= meta_q;
        end
    end
    assign o_q = sync_q;
endmodule
`default_nettype wire

// ---- src/pnp_nvm_cmd.v ----
// serial command handler for the stored wiper settings of four channels
// What this block does
// - opcode 1101 erases the whole 9-bit word at the addressed slot.
// - opcode 0010 programs the slot with mode bit from byte 1 lsb and wiper bits from byte 2.
// - opcode 0011 copies the channel's wiper and mode bit into the slot, ignoring data.
// - opcode 1010 fetches the addressed 9-bit stored word for the next frame.
// - opcode 1100 fetches the wiper and mode bit of the channel in the two low address bits.
// - the frame after a read shifts out the fetched word, mode bit then eight wiper bits.
// - serial output changes on the falling clock edge.
// - a store completes within 2 ms.
// - a command is exactly 24 clocks under low select, input sampled on rising edges.
// - upper two address bits pick the slot, lower two pick the channel.
// - each slot holds eight wiper bits plus one buffer mode bit.
`timescale 1ns/1ps
`default_nettype none
`include "pnp_defines.vh"
module pnp_nvm_cmd (
    input  wire       i_clk,
    input  wire       i_rstn,
    input  wire       i_sclk,
    input  wire       i_cs_n,
    input  wire       i_sdi,
    output reg        o_sdo,
    output reg        o_sdo_oe_n,
    output reg        o_ready,
    output reg [31:0] o_wiper_flat,
    output reg [3:0]  o_mode
);
    // one-hot store sequencer states
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_STORE = 3'b010;
    localparam [2:0] ST_DONE  = 3'b100;
    // whole busy time in clocks, start and done edges included
    localparam [21:0] STORE_CYC = `PNP_STORE_CYC;

    // storage: 4 channels x 4 slots, index {chan, slot}
    reg [8:0]  slot_mem_q [0:15];
    reg [23:0] shift_q;
    reg [23:0] out_q;
    reg [4:0]  bit_cnt_q;
    reg        sclk_q;
    reg        cs_n_q;
    reg [2:0]  state_q;
    reg [21:0] wait_q;
    reg [3:0]  st_idx_q;
    reg [8:0]  st_val_q;
    reg        st_erase_q;
    wire [2:0] pins_s;
    wire       sclk_s;
    wire       cs_n_s;
    wire       sdi_s;
    wire       rise;
    wire       fall;
    wire [23:0] frame;
    wire [3:0]  op;
    wire [1:0]  slot;
    wire [1:0]  chan;
    wire [3:0]  idx;
    wire        frame_end;
    wire        frame_full;
    integer     k;

    // pins cross into the system clock before any use
    // select crosses inverted so the flops' reset value means deselected;
    // otherwise sdo would be enabled for two clocks after reset
    pnp_sync #(.W(3)) u_sync (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_d    ({i_sclk, ~i_cs_n, i_sdi}),
        .o_q    (pins_s)
    );
    assign sclk_s = pins_s[2];
    assign cs_n_s = ~pins_s[1];
    assign sdi_s  = pins_s[0];
    assign rise   = sclk_s & ~sclk_q & ~cs_n_s;
    assign fall   = ~sclk_s & sclk_q & ~cs_n_s;

    // full frame including the bit arriving now
    assign frame = {shift_q[22:0], sdi_s};
    assign op    = frame[`PNP_OP_MSB:`PNP_OP_LSB];
    assign slot  = frame[`PNP_SLOT_MSB:`PNP_SLOT_LSB];
    assign chan  = frame[`PNP_CHAN_MSB:`PNP_CHAN_LSB];
    assign idx   = {chan, slot};
    // a frame acts only on its 24th rising edge; short frames are dropped
    assign frame_end = rise && (bit_cnt_q == (`PNP_FRAME_BITS - 5'h01));
    // all 24 bits are in: the closing fall must not shift the new answer
    assign frame_full = (bit_cnt_q == `PNP_FRAME_BITS);

    // tap word of a channel as {mode, wiper}
    function [8:0] tap_word;
        input [1:0]  c;
        input [31:0] w;
        input [3:0]  m;
        begin
            tap_word = {m[c], w[c*8 +: 8]};
        end
    endfunction

    // opcodes that start a store, for the busy sequencer
    function is_store_op;
        input [3:0] o;
        begin
            is_store_op = (o == `PNP_OP_ERASE) || (o == `PNP_OP_PROG) ||
                          (o == `PNP_OP_PROG_TAP);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // serial receive and transmit
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sclk_q     <= 1'b0;
            cs_n_q     <= 1'b1;
            shift_q    <= 24'h000000;
            out_q      <= 24'h000000;
            bit_cnt_q  <= 5'h00;
            o_sdo      <= 1'b0;
            o_sdo_oe_n <= 1'b1;
        end else begin
            sclk_q <= sclk_s;
            cs_n_q <= cs_n_s;
            o_sdo_oe_n <= cs_n_s;
            if (cs_n_s) begin
                bit_cnt_q <= 5'h00;
            end else if (rise) begin
                shift_q   <= frame;
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
            // first bit appears when select falls, rest on falling edges;
            // the fall after the 24th rise would eat bit 23 of a new answer
            if (cs_n_q && !cs_n_s) begin
                o_sdo <= out_q[23];
            end else if (fall && !frame_full) begin
                o_sdo <= out_q[22];
                out_q <= {out_q[22:0], 1'b0};
            end
            // load next frame's answer; non-reads return zeros
            if (frame_end) begin
                if (op == `PNP_OP_READ_NV) begin
                    out_q <= {15'h0000, slot_mem_q[idx]};
                end else if (op == `PNP_OP_READ_TAP) begin
                    out_q <= {15'h0000,
                              tap_word(chan, o_wiper_flat, o_mode)};
                end else begin
                    out_q <= 24'h000000;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // store sequencer and ready indicator
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q    <= ST_IDLE;
            wait_q     <= 22'h000000;
            st_idx_q   <= 4'h0;
            st_val_q   <= `PNP_ERASED_WORD;
            st_erase_q <= 1'b0;
            o_ready    <= 1'b1;
            o_wiper_flat <= {4{`PNP_TAP_RESET}};
            o_mode     <= 4'h0;
            for (k = 0; k < 16; k = k + 1) begin
                slot_mem_q[k] <= `PNP_ERASED_WORD;
            end
        end else begin
            case (state_q)
                ST_IDLE: begin
                    // store commands arriving while busy are ignored; reads are still served
                    if (frame_end && is_store_op(op)) begin
                        st_idx_q   <= idx;
                        st_erase_q <= (op == `PNP_OP_ERASE);
                        if (op == `PNP_OP_PROG) begin
                            st_val_q <= {frame[`PNP_MODE_BIT],
                                         frame[7:0]};
                        end else begin
                            // copy takes the tap value at command time
                            st_val_q <= tap_word(chan, o_wiper_flat,
                                                 o_mode);
                        end
                        // load and done edges make up the two cycles left
                        wait_q  <= STORE_CYC - 22'h000002;
                        o_ready <= 1'b0;
                        state_q <= ST_STORE;
                    end
                end
                ST_STORE: begin
                    // count the store time down; ready stays low
                    if (wait_q == 22'h000000) begin
                        state_q <= ST_DONE;
                    end else begin
                        wait_q <= wait_q - 22'h000001;
                    end
                end
                ST_DONE: begin
                    // program only clears bits, so an unerased slot
                    // keeps stale zeros: why erase must come first
                    if (st_erase_q) begin
                        slot_mem_q[st_idx_q] <= `PNP_ERASED_WORD;
                    end else begin
                        slot_mem_q[st_idx_q] <=
                            slot_mem_q[st_idx_q] & st_val_q;
                    end
                    o_ready <= 1'b1;
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                    o_ready <= 1'b1;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- dv/pnp_chk_asserts.sv ----
// port assertions for the stored-setting command block
`timescale 1ns/1ps
`default_nettype none
module pnp_chk (
    input wire logic        i_clk,
    input wire logic        i_rstn,
    input wire logic        i_sclk,
    input wire logic        i_cs_n,
    input wire logic        o_sdo,
    input wire logic        o_sdo_oe_n,
    input wire logic        o_ready,
    input wire logic [31:0] o_wiper_flat,
    input wire logic [3:0]  o_mode
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    logic [2:0]  up_q;
    logic [14:0] busy_q;
    // settle count keeps $past out of reset; busy_q counts ready-low cycles
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            up_q   <= 3'h0;
            busy_q <= 15'h0;
        end else begin
            up_q   <= up_q + {2'h0, up_q != 3'h7};
            busy_q <= o_ready ? 15'h0 : busy_q + 15'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_store_start;
        $fell(o_ready);
    endsequence
    sequence s_store_end;
        $rose(o_ready);
    endsequence
    chk_oe_tracks_cs: assert property (up_q == 3'h7 |->
        o_sdo_oe_n == $past(i_cs_n, 3)) else $error("sdo enable off");
    chk_sdo_on_fall: assert property ($changed(o_sdo) |-> !i_sclk)
        else $error("sdo moved while sclk high");
    chk_store_bound: assert property (!o_ready |-> busy_q < 15'h4e20)
        else $error("store too long");
    chk_busy_holds: assert property (s_store_end |-> busy_q >= 15'h4e10)
        else $error("store ended early");
    chk_busy_whole: assert property (s_store_start |-> !o_ready [*8])
        else $error("busy pulse too short");
    chk_busy_after_frame: assert property (s_store_start |->
        !$past(i_cs_n, 5)) else $error("busy without a frame");
    chk_ready_spacing: assert property (s_store_end |=> o_ready [*8])
        else $error("busy again too soon");
    chk_wiper_steady: assert property ($stable(o_wiper_flat)
        && $stable(o_mode)) else $error("wiper changed");
endmodule
`default_nettype wire

// ---- dv/pnp_host.sv ----
// spi host model sending 24-bit frames
`timescale 1ns/1ps
`default_nettype none
module pnp_host (
    input  wire logic i_clk,
    input  wire logic i_sdo,
    input  wire logic i_sdo_oe_n,
    input  wire logic i_ready,
    output var  logic o_sclk,
    output var  logic o_cs_n,
    output var  logic o_sdi
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi  = 1'b0;
    end
    // msb first, 800 ns sclk; sdi moves and sdo is taken on the fall
    task automatic xfer(input logic [23:0] c, output logic [23:0] rsp);
        int i;
        @(negedge i_clk) o_cs_n = 1'b0;
        for (i = 23; i >= 0; i--) begin
            o_sdi = c[i];
            repeat (4) @(negedge i_clk);
            o_sclk = 1'b1;
            repeat (4) @(negedge i_clk);
            rsp[i] = i_sdo_oe_n ? 1'bx : i_sdo;
            o_sclk = 1'b0;
        end
        repeat (4) @(negedge i_clk);
        o_cs_n = 1'b1;
        o_sdi  = ~o_sdi; // released line shows no stale value
        repeat (4) @(negedge i_clk);
        // wait for ready, then the select gap
        // a ready that never returns is caught by the bench timeout
        while (i_ready !== 1'b1) @(negedge i_clk);
        repeat (6) @(negedge i_clk);
    endtask
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// bench top: host model, block and reference model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        i_clk  = 1'b0;
    logic        i_rstn = 1'b0;
    wire         sclk, cs_n, sdi, sdo, sdo_oe_n, ready;
    wire  [31:0] wip;
    wire  [3:0]  mode;
    logic [8:0]  nv [16];
    logic [8:0]  pend = 9'h0;
    logic [31:0] seed = 32'h949db8be;
    logic [31:0] r;
    int          fail_count = 0;
    int          cmp_count  = 0;
    int          cyc        = 0;
    always #50 i_clk = ~i_clk;
    pnp_nvm_cmd u_dut (.i_clk, .i_rstn, .i_sclk(sclk), .i_cs_n(cs_n),
        .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n), .o_ready(ready),
        .o_wiper_flat(wip), .o_mode(mode));
    pnp_host u_host (.i_clk, .i_sdo(sdo), .i_sdo_oe_n(sdo_oe_n),
        .i_ready(ready), .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string n, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("FAIL %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // one frame with random data bytes; reply is last frame's answer
    task automatic run(input logic [3:0] op, input logic [3:0] a);
        logic [23:0] rsp;
        r = rnd();
        u_host.xfer({op, a, r[15:0]}, rsp);
        check("sdo", {8'h0, rsp}, {23'h0, pend});
        pend = 9'h0;
        case (op)
            4'hd: nv[a] = 9'h1ff;
            4'h2: nv[a] = r[8:0];
            4'h3: nv[a] = 9'h080;
            4'ha: pend = nv[a];
            4'hc: pend = 9'h080;
            default: pend = 9'h0;
        endcase
    endtask
    initial begin
        foreach (nv[i]) nv[i] = 9'h1ff;
        repeat (2) @(negedge i_clk);
        i_rstn = 1'b1;
        repeat (4) @(negedge i_clk);
        run(4'ha, 4'h5);
        run(4'hc, 4'hb);
        run(4'h0, 4'h0);
        run(4'hd, 4'h6);
        run(4'h2, 4'h6);
        run(4'h3, 4'h9);
        run(4'ha, 4'h6);
        run(4'ha, 4'h9);
        run(4'h0, 4'h0);
        check("wiper", wip, 32'h80808080);
        check("mode", {28'h0, mode}, 32'h0);
        end_sim();
    end
    // hang guard: three stores take about 62000 cycles
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 90000) begin
            fail_count++;
            end_sim();
        end
    end
endmodule
bind pnp_nvm_cmd pnp_chk u_chk (.i_clk, .i_rstn, .i_sclk, .i_cs_n, .o_sdo,
    .o_sdo_oe_n, .o_ready, .o_wiper_flat, .o_mode);
`default_nettype wire
